/* File: pkg/tick_wdog_params.svh */
// offsets, field positions, reset values and timing counts of the tick/watchdog block
`ifndef TICK_WDOG_PARAMS_SVH
`define TICK_WDOG_PARAMS_SVH

// register indices; byte address is four times the index
`define TWD_IDX_TICK_CTRL 6'h14
`define TWD_IDX_TICK_FLAG 6'h15
`define TWD_IDX_WDOG_CTRL 6'h16
`define TWD_IDX_SERVICE 6'h17
`define TWD_ADDR(idx) ({(idx), 2'h0})

// tick_control fields
`define TWD_TC_IRQ_EN 7
`define TWD_TC_STOP_WAIT 6
`define TWD_TC_STOP_DBG 5
`define TWD_TC_BYPASS 4
// tick_flag field
`define TWD_TF_FLAG 7
// watchdog_monitor_control fields
`define TWD_WC_MON_EN 7
`define TWD_WC_FORCE_MON 6
`define TWD_WC_FORCE_FAIL 5
`define TWD_WC_WINDOW 4
`define TWD_WC_RST_DIS 3

// reset values
`define TWD_TICK_RATE_RST 3'h0
`define TWD_WDOG_RATE_RST 3'h7

// service values
`define TWD_SVC_ARM 8'h55
`define TWD_SVC_FIRE 8'hAA

// timing: clock rate and clock monitor delay (least time, rounded up)
`define TWD_CLK_MHZ 125
`define TWD_CM_DELAY_NS 2000
`define TWD_CM_CYCLES ((`TWD_CM_DELAY_NS * `TWD_CLK_MHZ + 999) / 1000)

`endif

/* File: pkg/tick_wdog_pkg.sv */
// types shared by the tick/watchdog block
package tick_wdog_pkg;
    // watchdog service sequence state
    typedef enum logic [1:0] {
        SVC_IDLE  = 2'b01,
        SVC_ARMED = 2'b10
    } svc_state_e;
    // cause of the last requested system reset
    typedef enum logic [1:0] {
        CAUSE_NONE   = 2'b00,
        CAUSE_CLKMON = 2'b01,
        CAUSE_WDOG   = 2'b10
    } reset_cause_e;
endpackage

/* File: core/periodic_tick_watchdog_clock_monitor.sv */
// periodic tick, windowed watchdog and clock monitor with an Avalon-MM register slave
//
// Overview of operation
// - tick rate code 0 is off; codes 1..7 divide by 2^13..2^19.
// - tick flag bit 7 sets at each tick period end, zero until then.
// - writing one to the flag bit clears it; zero leaves it.
// - tick interrupt request follows the flag while the enable bit is one.
// - stop-in-wait halts divider and watchdog in wait; write-once in normal modes.
// - stop-in-debug halts divider and watchdog in debug; write-once in normal modes.
// - bypass test bit makes first stage divide by 4; special modes only.
// - monitor detects missing reference edges using a delay independent of that clock.
// - enabled monitor failure gives clock reset or fallback; force bit overrides enable.
// - force-monitor is write-once in normal modes and keeps monitor on.
// - force-failure test bit forces watchdog and/or monitor reset per enables.
// - when both failures are forced, highest-priority reset is serviced.
// - watchdog rate 0 disables; 1..7 give 2^13,15,17,19,21,22,23; write-once in normal modes.
// - window mode allows service only in final quarter; early writes reset.
// - first value repeatable in window; second restarts count, wait next window.
// - watchdog restart does not clear the shared prescaler stage.
// - reset-disable blocks all resets; special-only, resets to one in special.
// - first then second value before time-out; others reset; reads zero.
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "tick_wdog_params.svh"

module periodic_tick_watchdog_clock_monitor (
    input wire logic ref_clk, // module clock, 125 MHz
    input wire logic rst_n, // async reset, active low
    input wire logic [7:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data, low byte used
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    input wire logic special_mode, // part in a special mode
    input wire logic wait_mode, // processor in wait
    input wire logic debug_mode, // background debug active
    input wire logic loop_supply_ok, // loop supply high, sets monitor enable at reset
    input wire logic fallback_allow, // clock gen accepts fallback instead of reset
    input wire logic reference_clock, // external reference, asynchronous
    output logic tick_irq, // periodic tick interrupt request
    output logic system_reset_req, // one-cycle reset request
    output var tick_wdog_pkg::reset_cause_e reset_cause, // cause of last reset request
    output logic fallback_req // fallback clock mode request
);
    import tick_wdog_pkg::*;

    // ************************************************************
    // register state
    // ************************************************************
    logic boot_r, ack_r;
    logic tick_irq_enable_r, stop_in_wait_r, stop_in_debug_r, divider_bypass_test_r;
    logic [2:0] tick_rate_r, wdog_rate_r;
    logic tick_flag_r;
    logic monitor_enable_r, force_monitor_r, force_failure_test_r, window_mode_r;
    logic reset_disable_r;
    logic lk_wait_r, lk_dbg_r, lk_fmon_r, lk_win_r, lk_rate_r;
    logic [31:0] readdata_r;
    logic [12:0] pre_r;
    logic [10:0] chain_r, wd_cnt_r;
    svc_state_e svc_r;
    logic ref_s1_r, ref_s2_r, ref_s3_r, ref_lvl_r, cm_done_r;
    logic [8:0] cm_cnt_r;
    logic sys_rst_r, fallback_r;
    reset_cause_e cause_r;

    localparam logic [8:0] CM_LAST = 9'(`TWD_CM_CYCLES - 1);

    // low n bits of v all ones
    function automatic logic low_ones(input logic [10:0] v, input logic [2:0] n);
        logic [10:0] m;
        m = (11'h1 << n) - 11'h1;
        return (v & m) == m;
    endfunction

    // watchdog period in first-stage ticks
    function automatic logic [10:0] wd_period(input logic [2:0] code);
        logic [10:0] p;
        case (code)
            3'h1: p = 11'h001;
            3'h2: p = 11'h004;
            3'h3: p = 11'h010;
            3'h4: p = 11'h040;
            3'h5: p = 11'h100;
            3'h6: p = 11'h200;
            default: p = 11'h400;
        endcase
        return p;
    endfunction

    // ************************************************************
    // bus decode
    // ************************************************************
    logic wr_go, rd_take, wr_lane;
    logic hit_tc, hit_tf, hit_wc, hit_svc;
    logic [7:0] wd8;

    // every access answers at the second edge
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign wr_go = avs_write & ack_r;
    assign rd_take = avs_read & ~ack_r;
    assign wr_lane = avs_byteenable[0];
    assign wd8 = avs_writedata[7:0];
    assign avs_readdata = readdata_r;

    // address decode
    always_comb begin
        hit_tc = 1'b0;
        hit_tf = 1'b0;
        hit_wc = 1'b0;
        hit_svc = 1'b0;
        if (avs_address == `TWD_ADDR(`TWD_IDX_TICK_CTRL)) begin
            hit_tc = 1'b1;
        end else if (avs_address == `TWD_ADDR(`TWD_IDX_TICK_FLAG)) begin
            hit_tf = 1'b1;
        end else if (avs_address == `TWD_ADDR(`TWD_IDX_WDOG_CTRL)) begin
            hit_wc = 1'b1;
        end else if (avs_address == `TWD_ADDR(`TWD_IDX_SERVICE)) begin
            hit_svc = 1'b1;
        end
    end

    logic w_tc, w_tf, w_wc, w_svc, norm;
    assign w_tc = wr_go & wr_lane & hit_tc;
    assign w_tf = wr_go & wr_lane & hit_tf;
    assign w_wc = wr_go & wr_lane & hit_wc;
    assign w_svc = wr_go & wr_lane & hit_svc;
    assign norm = ~special_mode;

    // handshake acknowledge
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read | avs_write) & ~ack_r;
        end
    end

    // read data, service register reads zero, unmapped reads zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            readdata_r <= 32'h0000_0000;
        end else if (rd_take) begin
            readdata_r <= 32'h0000_0000;
            if (hit_tc) begin
                readdata_r[7:0] <= {tick_irq_enable_r, stop_in_wait_r, stop_in_debug_r,
                                    divider_bypass_test_r, 1'b0, tick_rate_r};
            end else if (hit_tf) begin
                readdata_r[`TWD_TF_FLAG] <= tick_flag_r;
            end else if (hit_wc) begin
                readdata_r[7:0] <= {monitor_enable_r, force_monitor_r, force_failure_test_r,
                                    window_mode_r, reset_disable_r, wdog_rate_r};
            end
        end
    end

    // ************************************************************
    // control registers
    // ************************************************************
    // tick control: write-once bits locked on first normal-mode write
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_irq_enable_r <= 1'b0;
            stop_in_wait_r <= 1'b0;
            stop_in_debug_r <= 1'b0;
            divider_bypass_test_r <= 1'b0;
            tick_rate_r <= `TWD_TICK_RATE_RST;
            lk_wait_r <= 1'b0;
            lk_dbg_r <= 1'b0;
        end else if (w_tc) begin
            tick_irq_enable_r <= wd8[`TWD_TC_IRQ_EN];
            tick_rate_r <= wd8[2:0];
            if (!lk_wait_r) begin
                stop_in_wait_r <= wd8[`TWD_TC_STOP_WAIT];
            end
            if (!lk_dbg_r) begin
                stop_in_debug_r <= wd8[`TWD_TC_STOP_DBG];
            end
            if (special_mode) begin
                divider_bypass_test_r <= wd8[`TWD_TC_BYPASS];
            end
            lk_wait_r <= lk_wait_r | norm;
            lk_dbg_r <= lk_dbg_r | norm;
        end
    end

    // watchdog/monitor control; reset values caught just after reset release
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_r <= 1'b0;
            monitor_enable_r <= 1'b0;
            force_monitor_r <= 1'b0;
            force_failure_test_r <= 1'b0;
            window_mode_r <= 1'b0;
            reset_disable_r <= 1'b1;
            wdog_rate_r <= `TWD_WDOG_RATE_RST;
            lk_fmon_r <= 1'b0;
            lk_win_r <= 1'b0;
            lk_rate_r <= 1'b0;
        end else if (!boot_r) begin
            boot_r <= 1'b1;
            monitor_enable_r <= loop_supply_ok;
            reset_disable_r <= special_mode;
        end else if (w_wc) begin
            monitor_enable_r <= wd8[`TWD_WC_MON_EN];
            if (!lk_fmon_r) begin
                force_monitor_r <= wd8[`TWD_WC_FORCE_MON];
            end
            if (!lk_win_r) begin
                window_mode_r <= wd8[`TWD_WC_WINDOW];
            end
            if (!lk_rate_r) begin
                wdog_rate_r <= wd8[2:0];
            end
            if (special_mode) begin
                force_failure_test_r <= wd8[`TWD_WC_FORCE_FAIL];
                reset_disable_r <= wd8[`TWD_WC_RST_DIS];
            end
            lk_fmon_r <= lk_fmon_r | norm;
            lk_win_r <= lk_win_r | norm;
            lk_rate_r <= lk_rate_r | norm;
        end
    end

    // ************************************************************
    // divider chain and periodic tick
    // ************************************************************
    logic halted, stage_tick, tick_fire;
    assign halted = (stop_in_wait_r & wait_mode) | (stop_in_debug_r & debug_mode);
    // first stage: 2^13, or 4 when bypassed
    assign stage_tick = ~halted & (divider_bypass_test_r ? (pre_r[1:0] == 2'h3)
                                                         : (pre_r == 13'h1FFF));
    // code k taps the chain at 2^(12+k)
    assign tick_fire = stage_tick & (tick_rate_r != 3'h0)
                     & low_ones(chain_r, 3'(tick_rate_r - 3'h1));

    // shared free-running chain, cleared by reset only
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_r <= 13'h0000;
            chain_r <= 11'h000;
        end else if (!halted) begin
            pre_r <= pre_r + 13'h0001;
            if (stage_tick) begin
                chain_r <= chain_r + 11'h001;
            end
        end
    end

    // tick flag: set wins over a same-cycle clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_flag_r <= 1'b0;
        end else if (tick_fire) begin
            tick_flag_r <= 1'b1;
        end else if (w_tf && wd8[`TWD_TF_FLAG]) begin
            tick_flag_r <= 1'b0;
        end
    end

    assign tick_irq = tick_flag_r & tick_irq_enable_r;

    // ************************************************************
    // watchdog
    // ************************************************************
    logic wd_on, wd_timeout, win_open, svc_early, svc_bad, svc_fire, wd_fail;
    logic [10:0] wd_per;
    assign wd_on = wdog_rate_r != 3'h0;
    assign wd_per = wd_period(wdog_rate_r);
    assign wd_timeout = wd_on & stage_tick & (wd_cnt_r == wd_per - 11'h001);
    // final quarter of the period; empty at the fastest rate
    assign win_open = wd_cnt_r >= (wd_per - (wd_per >> 2));
    assign svc_early = wd_on & w_svc & window_mode_r & ~win_open;
    assign svc_bad = wd_on & w_svc & (wd8 != `TWD_SVC_ARM) & (wd8 != `TWD_SVC_FIRE);
    assign svc_fire = wd_on & w_svc & (wd8 == `TWD_SVC_FIRE) & (svc_r == SVC_ARMED)
                    & ~svc_early;
    assign wd_fail = wd_timeout | svc_early | svc_bad;

    // watchdog count; restart leaves the prescaler running
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_cnt_r <= 11'h000;
        end else if (!wd_on || svc_fire || wd_fail) begin
            wd_cnt_r <= 11'h000;
        end else if (stage_tick) begin
            wd_cnt_r <= wd_cnt_r + 11'h001;
        end
    end

    // service sequence: arm value repeatable, fire value only after arm
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            svc_r <= SVC_IDLE;
        end else begin
            case (svc_r)
                SVC_IDLE: begin
                    if (wd_on && w_svc && wd8 == `TWD_SVC_ARM && !svc_early) begin
                        svc_r <= SVC_ARMED;
                    end
                end
                SVC_ARMED: begin
                    if (svc_fire || wd_fail || !wd_on) begin
                        svc_r <= SVC_IDLE;
                    end
                end
                default: svc_r <= SVC_IDLE;
            endcase
        end
    end

    // ************************************************************
    // clock monitor
    // ************************************************************
    logic mon_active, ref_edge, cm_fail;
    assign mon_active = force_monitor_r | monitor_enable_r;
    assign ref_edge = (ref_s2_r == ref_s3_r) & (ref_s3_r != ref_lvl_r);
    assign cm_fail = mon_active & ~cm_done_r & (cm_cnt_r == CM_LAST) & ~ref_edge;

    // reference synchroniser and settled level
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_s1_r <= 1'b0;
            ref_s2_r <= 1'b0;
            ref_s3_r <= 1'b0;
            ref_lvl_r <= 1'b0;
        end else begin
            ref_s1_r <= reference_clock;
            ref_s2_r <= ref_s1_r;
            ref_s3_r <= ref_s2_r;
            if (ref_s2_r == ref_s3_r) begin
                ref_lvl_r <= ref_s3_r;
            end
        end
    end

    // edge-free time counted on the module clock
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cm_cnt_r <= 9'h000;
            cm_done_r <= 1'b0;
        end else if (ref_edge || !mon_active) begin
            cm_cnt_r <= 9'h000;
            cm_done_r <= 1'b0;
        end else if (cm_cnt_r != CM_LAST) begin
            cm_cnt_r <= cm_cnt_r + 9'h001;
        end else begin
            cm_done_r <= 1'b1;
        end
    end

    // ************************************************************
    // reset and fallback requests
    // ************************************************************
    logic force_go, cm_rst, wd_rst;
    assign force_go = w_wc & special_mode & wd8[`TWD_WC_FORCE_FAIL];
    assign cm_rst = (cm_fail & ~fallback_allow) | (force_go & mon_active);
    assign wd_rst = wd_fail | (force_go & wd_on);

    // clock monitor outranks the watchdog
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_rst_r <= 1'b0;
            cause_r <= CAUSE_NONE;
        end else begin
            sys_rst_r <= ~reset_disable_r & (cm_rst | wd_rst);
            if (!reset_disable_r && cm_rst) begin
                cause_r <= CAUSE_CLKMON;
            end else if (!reset_disable_r && wd_rst) begin
                cause_r <= CAUSE_WDOG;
            end
        end
    end

    // fallback request holds until reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fallback_r <= 1'b0;
        end else if (cm_fail && fallback_allow) begin
            fallback_r <= 1'b1;
        end
    end

    assign system_reset_req = sys_rst_r;
    assign reset_cause = cause_r;
    assign fallback_req = fallback_r;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    flag_set_a: assert property (tick_fire |=> tick_flag_r)
        else $error("tick flag not set after tick");
    flag_clear_a: assert property (w_tf && wd8[7] && !tick_fire |=> !tick_flag_r)
        else $error("tick flag not cleared by write of one");
    tick_irq_a: assert property (tick_irq_enable_r && tick_fire |=> tick_irq)
        else $error("tick interrupt missing");
    halt_freeze_a: assert property (halted && wd_on && !w_svc |=>
                                    $stable(pre_r) && $stable(chain_r) && $stable(wd_cnt_r))
        else $error("divider ran while halted");
    fmon_lock_a: assert property (force_monitor_r && lk_fmon_r && norm
                                  |=> force_monitor_r)
        else $error("forced monitor dropped in normal mode");
    rate_lock_a: assert property (lk_rate_r && norm |=> $stable(wdog_rate_r))
        else $error("locked watchdog rate changed");
    early_svc_a: assert property (svc_early && !reset_disable_r |=> system_reset_req)
        else $error("early service did not reset");
    bad_svc_a: assert property (svc_bad && !reset_disable_r |=>
                                reset_cause != CAUSE_NONE && system_reset_req)
        else $error("bad service value did not reset");
    restart_a: assert property (svc_fire && !wd_fail |=> wd_cnt_r == 11'h000)
        else $error("service did not restart count");
    rst_block_a: assert property (reset_disable_r && $past(reset_disable_r)
                                  |-> !system_reset_req)
        else $error("reset raised while disabled");
    both_prio_a: assert property (force_go && mon_active && wd_on && !reset_disable_r
                                  |=> reset_cause == CAUSE_CLKMON)
        else $error("clock monitor did not win priority");
    cm_timeout_a: assert property (mon_active && ref_edge
                                   ##1 (mon_active && !ref_edge)[*2] |-> !cm_fail)
        else $error("monitor fired right after an edge");
    bypass_a: assert property (divider_bypass_test_r && stage_tick
                               ##1 (!halted && divider_bypass_test_r)[*4] |-> stage_tick)
        else $error("bypassed stage not divide by four");

    tick_seen_c: cover property (tick_fire ##1 tick_irq);
    service_c: cover property (svc_r == SVC_ARMED ##[1:50] svc_fire);
    cm_fail_c: cover property (cm_fail);
    fallback_c: cover property (cm_fail && fallback_allow);

endmodule // periodic_tick_watchdog_clock_monitor
`default_nettype wire

/* File: bench/test_periodic_tick_watchdog_clock_monitor.sv */
// self-checking bench for the tick, watchdog and clock monitor block
`timescale 1ns/1ps
`default_nettype none
module test_periodic_tick_watchdog_clock_monitor;
    import tick_wdog_pkg::*;
    logic ref_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, special_mode = 1;
    logic wait_mode = 0, debug_mode = 0, loop_supply_ok = 0, fallback_allow = 0;
    logic reference_clock = 0, avs_waitrequest, tick_irq, system_reset_req, fallback_req;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [3:0] avs_byteenable = 4'hF;
    reset_cause_e reset_cause;
    int errors = 0, cmp_count = 0, pulses = 0, p0, i;
    logic [7:0] rows_a [5] = '{8'h50, 8'h54, 8'h58, 8'h5C, 8'h60};
    logic [31:0] rows_e [5] = '{32'h0, 32'h0, 32'h0F, 32'h0, 32'h0};
    periodic_tick_watchdog_clock_monitor DUT (.ref_clk(ref_clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .special_mode(special_mode), .wait_mode(wait_mode), .debug_mode(debug_mode),
        .loop_supply_ok(loop_supply_ok), .fallback_allow(fallback_allow),
        .reference_clock(reference_clock), .tick_irq(tick_irq),
        .system_reset_req(system_reset_req), .reset_cause(reset_cause),
        .fallback_req(fallback_req));
    // 125 MHz module clock
    always #4 ref_clk = ~ref_clk;
    // count reset request pulses
    always @(posedge ref_clk) if (system_reset_req === 1'b1) pulses++;
    task automatic test_done();
        $display("checks %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one bus cycle, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_read <= ~wr;
        avs_write <= wr;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h00);
        check(rd, e);
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic ref_edges();
        repeat (6) begin
            @(posedge ref_clk);
            reference_clock <= ~reference_clock;
            repeat (4) @(posedge ref_clk);
        end
    endtask
    task automatic expect_pulses(input int n, input logic [1:0] cause);
        repeat (3) @(posedge ref_clk);
        check(pulses - p0, n);
        if (n > 0) check(reset_cause, cause);
        p0 = pulses;
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        test_done();
    end
    // ************************************
    // main sequence
    // ************************************
    initial begin
        do_reset();
        p0 = pulses;
        for (i = 0; i < 5; i++) rd_chk(rows_a[i], rows_e[i]);
        // fast tick through bypass, then flag clear rules
        bus(1'b1, 8'h50, 8'h91);
        i = 0;
        while (tick_irq !== 1'b1 && i < 100) begin
            @(negedge ref_clk);
            i++;
        end
        check(tick_irq, 1'b1);
        rd_chk(8'h54, 32'h80);
        bus(1'b1, 8'h50, 8'h10);
        @(negedge ref_clk);
        check(tick_irq, 1'b0);
        rd_chk(8'h50, 32'h10);
        bus(1'b1, 8'h54, 8'h00);
        rd_chk(8'h54, 32'h80);
        bus(1'b1, 8'h54, 8'h80);
        rd_chk(8'h54, 32'h00);
        // stop in wait, then stop in debug, freeze the fast tick
        bus(1'b1, 8'h50, 8'hF1);
        wait_mode <= 1'b1;
        bus(1'b1, 8'h54, 8'h80);
        repeat (40) @(posedge ref_clk);
        check(tick_irq, 1'b0);
        wait_mode <= 1'b0;
        debug_mode <= 1'b1;
        repeat (40) @(posedge ref_clk);
        check(tick_irq, 1'b0);
        debug_mode <= 1'b0;
        repeat (40) @(posedge ref_clk);
        check(tick_irq, 1'b1);
        bus(1'b1, 8'h50, 8'h00);
        // bad service blocked, then allowed, then forced failures
        bus(1'b1, 8'h58, 8'h09);
        bus(1'b1, 8'h5C, 8'h12);
        expect_pulses(0, 2'b00);
        bus(1'b1, 8'h58, 8'h01);
        bus(1'b1, 8'h5C, 8'h12);
        expect_pulses(1, 2'b10);
        bus(1'b1, 8'h58, 8'h21);
        expect_pulses(1, 2'b10);
        ref_edges();
        bus(1'b1, 8'h58, 8'h81);
        bus(1'b1, 8'h58, 8'hA1);
        expect_pulses(1, 2'b01);
        bus(1'b1, 8'h58, 8'h80);
        bus(1'b1, 8'h58, 8'hA0);
        expect_pulses(1, 2'b01);
        repeat (300) @(posedge ref_clk);
        expect_pulses(1, 2'b01);
        fallback_allow <= 1'b1;
        ref_edges();
        repeat (300) @(posedge ref_clk);
        check(fallback_req, 1'b1);
        expect_pulses(0, 2'b00);
        // normal mode: write-once locks and service sequence
        special_mode <= 1'b0;
        fallback_allow <= 1'b0;
        do_reset();
        p0 = pulses;
        rd_chk(8'h58, 32'h07);
        bus(1'b1, 8'h58, 8'h03);
        rd_chk(8'h58, 32'h03);
        bus(1'b1, 8'h58, 8'h5D);
        rd_chk(8'h58, 32'h03);
        bus(1'b1, 8'h50, 8'h97);
        rd_chk(8'h50, 32'h87);
        bus(1'b1, 8'h5C, 8'h55);
        bus(1'b1, 8'h5C, 8'hAA);
        expect_pulses(0, 2'b00);
        bus(1'b1, 8'h5C, 8'h12);
        expect_pulses(1, 2'b10);
        // fresh normal run: early window write, forced monitor stays on
        do_reset();
        p0 = pulses;
        bus(1'b1, 8'h58, 8'h53); // window only at a slower rate
        bus(1'b1, 8'h5C, 8'h55);
        expect_pulses(1, 2'b10);
        bus(1'b1, 8'h58, 8'h00);
        rd_chk(8'h58, 32'h53);
        repeat (300) @(posedge ref_clk);
        expect_pulses(1, 2'b01);
        test_done();
    end
endmodule // test_periodic_tick_watchdog_clock_monitor
`default_nettype wire
